/* rtl/ebus_params.svh */
`ifndef EBUS_PARAMS_SVH
`define EBUS_PARAMS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define EB_ADDR_W      20
`define EB_DATA_W      16

// ----------------------------------------------------------------
// address fields
// ----------------------------------------------------------------
// top address bit picks the upper memory region
`define EB_REGION_BIT  19
`define EB_ROW_HI      19
`define EB_ROW_LO      10
`define EB_COL_HI      9
`define EB_COL_LO      0
`define EB_ROWCOL_W    10

// ----------------------------------------------------------------
// timing: bus clock is clk / 2, one t-state is two clk cycles
// ----------------------------------------------------------------
`define EB_PHASE_FIRST 1'b0
`define EB_PHASE_LAST  1'b1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define EB_ADDR_RST    20'h00000
`define EB_DATA_RST    16'h0000

`endif

/* rtl/ebus_pkg.sv */
package ebus_pkg;
  `include "ebus_params.svh"

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PRE,
    ST_T1,
    ST_T2,
    ST_T3,
    ST_TW,
    ST_T4
  } bus_state_e;

  typedef struct packed {
    logic                   write;
    logic [`EB_ADDR_W-1:0]  addr;
    logic [`EB_DATA_W-1:0]  wdata;
  } bus_req_s;

  typedef struct packed {
    logic [`EB_ADDR_W-1:0]  nonmux_address_out;
    logic                   nonmux_oe;
    logic [`EB_DATA_W-1:0]  muxed_addr_data_out;
    logic                   muxed_oe;
    logic                   ale;
    logic                   ale_oe;
    logic                   pulldown_en;
    logic                   muxed_pulldown_en;
  } bus_pads_s;
endpackage

/* rtl/ready_sync.sv */
module ready_sync
  import ebus_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic async_ready_in,
  input  wire logic sync_ready_in,
  output logic      ready
);

  logic async_meta;
  logic async_sync;

  // ----------------------------------------------------------------
  // async ready crossing
  // ----------------------------------------------------------------
  // a late rising edge costs one more clock, never a lost ready
  always_ff @(posedge clk) begin
    if (rst) begin
      async_meta <= 1'b0;
      async_sync <= 1'b0;
    end else begin
      async_meta <= async_ready_in; // R12
      async_sync <= async_meta; // R14
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ready <= 1'b0;
    end else begin
      ready <= async_sync | sync_ready_in; // R12
    end
  end

endmodule // ready_sync

/* rtl/external_bus_cycle_interface.sv */
// What this block does
// R01: nonmux address half bus clock before muxed
// R02: reset or hold floats nonmux address, pulled
// R03: dram mode drives row then column address
// R04: lower and upper regions dram independently
// R05: muxed pins carry address in t1
// R06: data phases drive writes, float for reads
// R07: strap suppresses muxed address phase
// R08: muxed pins pulled in reset, bare in hold
// R09: reset captures muxed pins into strap register
// R10: latch strobe falls with address valid
// R11: hold or reset floats latch strobe, pulled
// R12: async ready high completes the transfer
// R13: partner syncs ready for exact wait count
// R14: unsynced async ready may add one bus clock
// R15: no waits means both readies tied high; the partner model raises only the ready selected by use_async
// R16: unused async ready is tied low
// R17: wait states until ready, then finish
module external_bus_cycle_interface
  import ebus_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  req_valid,
  input  wire bus_req_s              req,
  output logic                       req_ready,
  output logic                       rsp_valid,
  output logic [`EB_DATA_W-1:0]      rsp_rdata,
  input  wire logic                  hold_req,
  output logic                       hold_ack,
  input  wire logic                  dram_lower_en,
  input  wire logic                  dram_upper_en,
  input  wire logic                  address_phase_strap,
  input  wire logic                  async_ready_in,
  input  wire logic                  sync_ready_in,
  input  wire logic [`EB_DATA_W-1:0] muxed_addr_data_bus,
  output bus_pads_s                  pads,
  output logic                       bus_clock_out,
  output logic [`EB_DATA_W-1:0]      reset_strap_capture,
  output logic                       addr_phase_off
);

  bus_state_e state;
  bus_state_e next_state;
  logic       phase;
  logic       next_phase;
  logic       next_hold;
  logic       take;
  logic       ready;
  logic       cur_dram;
  logic       t1_open;
  logic       t4_sample;
  logic       t4_done;
  bus_req_s   cur;

  function automatic logic in_dram(input logic [`EB_ADDR_W-1:0] a,
                                   input logic lo_en, input logic hi_en);
    in_dram = a[`EB_REGION_BIT] ? hi_en : lo_en; // R04
  endfunction

  ready_sync u_ready (
    .clk            (clk),
    .rst            (rst),
    .async_ready_in (async_ready_in),
    .sync_ready_in  (sync_ready_in),
    .ready          (ready)
  );

  // ----------------------------------------------------------------
  // bus clock and t-state phase
  // ----------------------------------------------------------------
  // phase 0 is the first half of a t-state, when the bus clock is high
  assign next_phase = ~phase;

  always_ff @(posedge clk) begin
    if (rst) begin
      phase         <= `EB_PHASE_FIRST;
      bus_clock_out <= 1'b0;
    end else begin
      phase         <= next_phase;
      bus_clock_out <= (next_phase == `EB_PHASE_FIRST);
    end
  end

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  // sampled on every reset cycle, so the last one before release wins
  always_ff @(posedge clk) begin
    if (rst) begin
      reset_strap_capture <= muxed_addr_data_bus; // R09
      addr_phase_off      <= address_phase_strap; // R07
    end
  end

  // ----------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------
  assign take = req_valid & req_ready;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (take) next_state = ST_PRE;
      ST_PRE:  next_state = ST_T1;
      ST_T1:   if (phase == `EB_PHASE_LAST) next_state = ST_T2;
      ST_T2:   if (phase == `EB_PHASE_LAST) next_state = ST_T3;
      ST_T3, ST_TW: begin
        if (phase == `EB_PHASE_LAST) next_state = ready ? ST_T4 : ST_TW; // R17
      end
      ST_T4:   if (phase == `EB_PHASE_LAST) next_state = ST_IDLE;
    endcase
  end

  // hold waits for idle, so a running cycle always finishes first
  assign next_hold = hold_req & (next_state == ST_IDLE);

  // ----------------------------------------------------------------
  // t-state strobes
  // ----------------------------------------------------------------
  // named once so the strobe, sample and reply logic agree on the halves
  assign t1_open   = (next_state == ST_T1) && (next_phase == `EB_PHASE_FIRST);
  assign t4_sample = (state == ST_T4) && (phase == `EB_PHASE_FIRST);
  assign t4_done   = (state == ST_T4) && (phase == `EB_PHASE_LAST);

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // dram choice is frozen at take; a later enable change waits for the next cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      cur      <= '0;
      cur_dram <= 1'b0;
    end else if (take) begin
      cur      <= req;
      cur_dram <= in_dram(req.addr, dram_lower_en, dram_upper_en);
    end
  end

  // ----------------------------------------------------------------
  // user side handshake
  // ----------------------------------------------------------------
  // requests open only on a first half so t1 lines up with the bus clock
  always_ff @(posedge clk) begin
    if (rst) begin
      req_ready <= 1'b0;
      hold_ack  <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= `EB_DATA_RST;
    end else begin
      req_ready <= (next_state == ST_IDLE) && (next_phase == `EB_PHASE_FIRST) && !hold_req;
      hold_ack  <= next_hold;
      rsp_valid <= t4_done;
      if (t4_sample && !cur.write) begin
        rsp_rdata <= muxed_addr_data_bus;
      end
    end
  end

  // ----------------------------------------------------------------
  // pad drivers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pads.nonmux_address_out  <= `EB_ADDR_RST;
      pads.nonmux_oe           <= 1'b0; // R02
      pads.pulldown_en         <= 1'b1; // R11
      pads.muxed_pulldown_en   <= 1'b1; // R08
    end else begin
      pads.nonmux_oe         <= !next_hold; // R02
      pads.pulldown_en       <= next_hold; // R11
      pads.muxed_pulldown_en <= 1'b0; // R08
      if (next_state == ST_PRE) begin
        // one clk ahead of t1: half a bus clock before the muxed address
        if (in_dram(req.addr, dram_lower_en, dram_upper_en)) begin
          pads.nonmux_address_out <= `EB_ADDR_W'(req.addr[`EB_ROW_HI:`EB_ROW_LO]); // R03
        end else begin
          pads.nonmux_address_out <= req.addr; // R01
        end
      end else if (next_state == ST_T2 && cur_dram) begin
        pads.nonmux_address_out <= `EB_ADDR_W'(cur.addr[`EB_COL_HI:`EB_COL_LO]); // R03
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pads.muxed_addr_data_out <= `EB_DATA_RST;
      pads.muxed_oe            <= 1'b0; // R08
    end else begin
      unique case (next_state)
        ST_T1: begin
          pads.muxed_addr_data_out <= cur.addr[`EB_DATA_W-1:0]; // R05
          pads.muxed_oe            <= !addr_phase_off; // R07
        end
        ST_T2, ST_T3, ST_TW, ST_T4: begin
          pads.muxed_addr_data_out <= cur.wdata;
          pads.muxed_oe            <= cur.write; // R06
        end
        default: begin
          pads.muxed_oe            <= 1'b0; // R08
        end
      endcase
    end
  end

  // strobe high in the first half of t1, falls mid t1 with address stable
  always_ff @(posedge clk) begin
    if (rst) begin
      pads.ale    <= 1'b0;
      pads.ale_oe <= 1'b0; // R11
    end else begin
      pads.ale    <= t1_open; // R10
      pads.ale_oe <= !next_hold; // R11
    end
  end

endmodule // external_bus_cycle_interface

/* test/ebus_monitor.sv */
module ebus_monitor
  import ebus_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        req_valid,
  input wire bus_req_s    req,
  input wire logic        req_ready,
  input wire logic        rsp_valid,
  input wire logic        hold_ack,
  input wire logic        dram_lower_en,
  input wire logic        dram_upper_en,
  input wire logic [15:0] muxed_addr_data_bus,
  input wire bus_pads_s   pads,
  input wire logic [15:0] reset_strap_capture,
  input wire logic        addr_phase_off
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic dram;
  assign dram = req.addr[19] ? dram_upper_en : dram_lower_en;
  sequence take_s; req_valid && req_ready; endsequence
  sequence lead_s; ##1 pads.nonmux_oe && pads.nonmux_address_out == $past(req.addr) ##1 pads.ale;
  endsequence
  sequence rowcol_s; ##1 pads.nonmux_address_out == {10'h000, $past(req.addr[19:10])}
    ##3 pads.nonmux_address_out == {10'h000, $past(req.addr[9:0], 4)}; endsequence
  reset_float_a: assert property (disable iff (1'b0) rst [*2] |->
    !pads.nonmux_oe && !pads.muxed_oe && !pads.ale_oe &&
    pads.pulldown_en && pads.muxed_pulldown_en)
    else $error("bus driven in reset");
  strap_capture_a: assert property (disable iff (1'b0) rst [*2] |=>
    reset_strap_capture == $past(muxed_addr_data_bus)) else $error("strap not captured");
  hold_float_a: assert property (hold_ack |-> !pads.nonmux_oe && !pads.muxed_oe &&
    !pads.ale_oe && pads.pulldown_en && !pads.muxed_pulldown_en) else $error("bus driven in hold");
  addr_lead_a: assert property (take_s ##0 !dram |-> lead_s) else $error("address lead");
  addr_phase_a: assert property ($fell(pads.ale) |->
    $past(pads.muxed_oe) != addr_phase_off) else $error("address phase");
  muxed_addr_a: assert property ($fell(pads.ale) && !addr_phase_off |->
    $past(pads.muxed_addr_data_out) == $past(req.addr[15:0], 3)) else $error("muxed address");
  dram_rowcol_a: assert property (take_s ##0 dram |-> rowcol_s) else $error("row col");
  data_phase_a: assert property (take_s |-> ##4 pads.muxed_oe == $past(req.write, 4))
    else $error("data phase drive");
  wait_extend_a: assert property (take_s |-> ##1 !rsp_valid [*8] ##[1:100] rsp_valid)
    else $error("cycle length");
endmodule // ebus_monitor

bind external_bus_cycle_interface ebus_monitor mon (.clk(clk), .rst(rst), .req_valid(req_valid),
  .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .hold_ack(hold_ack),
  .dram_lower_en(dram_lower_en), .dram_upper_en(dram_upper_en), .pads(pads),
  .muxed_addr_data_bus(muxed_addr_data_bus), .reset_strap_capture(reset_strap_capture),
  .addr_phase_off(addr_phase_off));

/* test/bus_partner_model.sv */
module bus_partner_model
  import ebus_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire bus_pads_s   pads,
  input  wire logic [15:0] strap,
  input  wire logic [3:0]  waits,
  input  wire logic        use_async,
  output logic             async_ready_in,
  output logic             sync_ready_in,
  output logic [15:0]      bus
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [16];
  logic [15:0] last;
  logic [3:0]  key;
  int          cnt;
  logic        rdy;
  // dram rows key the store too, so one address always maps to one word
  always_ff @(posedge clk) begin
    cnt <= pads.ale ? 0 : cnt + 1;
    if (pads.ale) key <= pads.nonmux_address_out[3:0];
    if (pads.muxed_oe && cnt > 0 && cnt < 8) mem[key] <= pads.muxed_addr_data_out;
    if (pads.muxed_oe) last <= pads.muxed_addr_data_out;
  end
  assign rdy = waits == 4'h0 || cnt >= 3 + 2 * waits;
  assign sync_ready_in = !use_async && rdy;
  assign async_ready_in = use_async && rdy;
  // released lines show the strap in reset and the stored word in the read window, else the inverse of the last value unless pulled down
  assign bus = pads.muxed_oe ? pads.muxed_addr_data_out : rst ? strap
    : (cnt > 0 && cnt < 10 + 2 * waits) ? mem[key]
    : pads.muxed_pulldown_en ? 16'h0000 : ~last;
endmodule // bus_partner_model

/* test/external_bus_cycle_interface_tb_top.sv */
module external_bus_cycle_interface_tb_top
  import ebus_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst = 1'b1, req_valid = 1'b0, hold_req = 1'b0, use_async = 1'b0;
  logic        dram_lower_en = 1'b0, dram_upper_en = 1'b0, address_phase_strap = 1'b0;
  logic        async_ready_in, sync_ready_in, req_ready, rsp_valid, hold_ack, bus_clock_out;
  logic        addr_phase_off;
  logic [3:0]  waits = 4'h0;
  logic [15:0] strap = 16'h0000, muxed_addr_data_bus, rsp_rdata, reset_strap_capture;
  bus_req_s    req = '0;
  bus_pads_s   pads;
  int          failures = 0, compares = 0, cycles = 0;

  external_bus_cycle_interface dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .hold_req(hold_req),
    .hold_ack(hold_ack), .dram_lower_en(dram_lower_en), .dram_upper_en(dram_upper_en),
    .address_phase_strap(address_phase_strap), .async_ready_in(async_ready_in),
    .sync_ready_in(sync_ready_in), .muxed_addr_data_bus(muxed_addr_data_bus), .pads(pads),
    .bus_clock_out(bus_clock_out), .reset_strap_capture(reset_strap_capture),
    .addr_phase_off(addr_phase_off));
  bus_partner_model far (.clk(clk), .rst(rst), .pads(pads), .strap(strap), .waits(waits),
    .use_async(use_async), .async_ready_in(async_ready_in), .sync_ready_in(sync_ready_in),
    .bus(muxed_addr_data_bus));

  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset(input logic [15:0] s, input logic st);
    strap = s;
    address_phase_strap = st;
    rst = 1'b1;
    repeat (16) @(negedge clk);
    chk(reset_strap_capture, s);
    chk({addr_phase_off, pads.nonmux_oe, pads.ale_oe, pads.muxed_pulldown_en}, {st, 3'h1});
    rst = 1'b0;
  endtask

  // one bus cycle; async waits may run one bus clock long through the synchroniser
  task automatic op(input logic w, input logic [19:0] a, input logic [15:0] d, input int wt,
                    input logic as);
    int n;
    waits = 4'(wt);
    use_async = as;
    req = '{write: w, addr: a, wdata: d};
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin @(negedge clk); n++; end
    chk(bus_clock_out, 1'b1);
    @(negedge clk);
    req_valid = 1'b0;
    chk(bus_clock_out, 1'b0);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 80) begin @(negedge clk); n++; end
    chk(n >= 9 + 2 * wt && n <= 9 + 2 * wt + 2 * (as && wt > 0), 1'b1);
    if (!w) chk(rsp_rdata, d);
  endtask

  task automatic rw_test;
    op(1'b1, 20'h00012, 16'h1234, 0, 1'b0);
    op(1'b1, 20'h00015, 16'h5A5A, 0, 1'b0);
    op(0, 20'h00012, 16'h1234, 0, 1'b0);
    op(0, 20'h00015, 16'h5A5A, 0, 1'b0);
  endtask

  task automatic wait_test;
    op(1'b1, 20'h00003, 16'hBEEF, 3, 1'b0);
    op(0, 20'h00003, 16'hBEEF, 2, 1'b1);
    op(0, 20'h00003, 16'hBEEF, 0, 1'b1);
  endtask

  task automatic dram_test;
    dram_lower_en = 1'b1;
    op(1'b1, 20'h00407, 16'hC0DE, 0, 1'b0);
    op(0, 20'h00407, 16'hC0DE, 0, 1'b0);
    dram_lower_en = 1'b0;
    dram_upper_en = 1'b1;
    op(1'b1, 20'h80C09, 16'h0F0F, 1, 1'b0);
    op(0, 20'h80C09, 16'h0F0F, 0, 1'b0);
    op(0, 20'h00012, 16'h1234, 0, 1'b0);
    dram_upper_en = 1'b0;
  endtask

  task automatic hold_test;
    hold_req = 1'b1;
    repeat (3) @(negedge clk);
    chk({hold_ack, req_ready, pads.muxed_oe, pads.muxed_pulldown_en, pads.ale_oe}, 5'h10);
    hold_req = 1'b0;
    repeat (2) @(negedge clk);
    chk(hold_ack, 1'b0);
  endtask

  initial begin
    do_reset(16'hA5C3, 1'b0);
    rw_test();
    wait_test();
    dram_test();
    hold_test();
    do_reset(16'h3C96, 1'b1);
    rw_test();
    complete_run();
  end
endmodule // external_bus_cycle_interface_tb_top
